/* File: tsh_highway.sv */
// Purpose: Receive and transmit system highway timing with the HDLC slot assigner.
// Assumes: Offsets are written already computed by software from the sync distance.
// Notes:   Rx logic runs on rx_system_clock, tx logic on tx_system_clock.
`default_nettype none
module tsh_highway
    import tsh_pkg::*;
#(
    parameter int RATIO_MAX = 8
) (
    input  wire logic                 rst_n,
    input  wire logic                 rx_system_clock,
    input  wire logic                 tx_system_clock,
    input  wire logic [1:0]           sys_clock_rate_select,
    input  wire logic [1:0]           sys_edge_select,
    input  wire logic [2:0]           rx_pin_function,
    input  wire logic [TSH_CW-1:0]    rx_offset,
    input  wire logic [TSH_CW-1:0]    tx_offset,
    input  wire logic [31:0]          rx_slot_select,
    input  wire logic [31:0]          tx_slot_select,
    input  wire logic                 tx_sig_mux_enable,
    input  wire logic                 hdlc_slot_insert_enable,
    input  wire tsh_hdlc_cfg_type     hdlc_cfg1,
    input  wire tsh_hdlc_cfg_type     hdlc_cfg2,
    input  wire tsh_hdlc_cfg_type     hdlc_cfg3,
    input  wire logic                 rx_sync_pulse_n,
    input  wire logic                 tx_sync_pulse_n,
    input  wire logic                 tx_multiframe_sync_n,
    input  wire logic                 rx_line_bit,
    input  wire logic                 rx_line_sig,
    input  wire logic                 tx_pcm_input,
    input  wire logic                 tx_signaling_input,
    input  wire logic                 hdlc_tx_bit,
    output logic                      rx_pcm_output,
    output logic                      rx_signaling_output,
    output logic                      rx_frame_marker,
    output logic                      hdlc_rx_bit,
    output logic                      hdlc_rx_valid,
    output logic [2:0]                hdlc_rx_channels,
    output logic                      tx_line_bit,
    output logic                      tx_line_valid,
    output logic                      hdlc_tx_take
);
    // The shift-based ratio logic only serves the four documented clock rates.
    if (RATIO_MAX != 8) begin : g_ratio_check
        $error("RATIO_MAX must be 8");
    end

    // Ratio of system clock to base rate: 1, 2, 4 or 8.
    logic [3:0]         ratio;
    logic [1:0]         rshift;
    logic [TSH_CW-1:0]  frame_len;
    assign rshift    = sys_clock_rate_select;
    assign ratio     = 4'h1 << rshift;
    assign frame_len = TSH_CW'(TSH_FRAME_BITS) << rshift;

    // Programmed offsets may reach past one frame, so the counters load the remainder.
    // offset modulo frame
    logic [TSH_CW-1:0]  rx_ofs_mod;
    logic [TSH_CW-1:0]  tx_ofs_mod;
    assign rx_ofs_mod = (rx_offset >= frame_len) ? rx_offset - frame_len : rx_offset;
    assign tx_ofs_mod = (tx_offset >= frame_len) ? tx_offset - frame_len : tx_offset;

    // ==========================================================
    // Receive domain
    // ==========================================================
    logic [1:0] rx_sync_ff;
    always_ff @(posedge rx_system_clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_ff <= 2'h3;
        end else begin
            rx_sync_ff <= {rx_sync_ff[0], rx_sync_pulse_n};
        end
    end

    tsh_rx_state_type rx_reg, rx_next;
    logic             rx_pulse;
    logic             marker_mode;
    logic [4:0]       rx_slot;
    logic [2:0]       rx_bitpos;
    logic             rx_base_edge;
    logic [TSH_CW-1:0] rx_bitcnt;

    assign marker_mode  = (rx_pin_function == TSH_RX_MARKER);
    assign rx_pulse     = !rx_sync_ff[1] && rx_reg.sync_d;
    assign rx_bitcnt    = rx_reg.clk_cnt >> rshift;
    assign rx_base_edge = (rx_reg.clk_cnt & TSH_CW'(ratio - 4'h1)) == '0;
    assign rx_slot      = (rx_bitcnt == '0) ? 5'h0 : 5'((rx_bitcnt - 1) >> 3);
    assign rx_bitpos    = 3'(rx_bitcnt - 1);

    // The sum may wrap the counter width, but the difference that remains is exact.
    // marker distance in frame
    logic [TSH_CW-1:0] rx_mk_dist;
    assign rx_mk_dist = (rx_reg.clk_cnt >= rx_ofs_mod) ? rx_reg.clk_cnt - rx_ofs_mod
                      : rx_reg.clk_cnt + frame_len - rx_ofs_mod;

    function automatic logic frame_ok(input logic [1:0] f, input logic odd);
        return (f == TSH_FR_BOTH) || (f == TSH_FR_EVEN && !odd) || (f == TSH_FR_ODD && odd);
    endfunction

    function automatic logic hdlc_hit(input tsh_hdlc_cfg_type c, input logic [4:0] s,
                                      input logic [2:0] b, input logic odd);
        return (c.slot == s) && c.bit_mask[3'h7 - b] && frame_ok(c.frames, odd);
    endfunction

    logic [2:0] rx_hits;
    always_comb begin
        rx_hits[0] = hdlc_slot_insert_enable && rx_slot_select[5'd31 - rx_slot]
                   && hdlc_cfg1.bit_mask[3'h7 - rx_bitpos];
        if (hdlc_cfg1.frames == TSH_FR_EVEN) begin
            rx_hits[0] = rx_hits[0] && !rx_reg.frame_cnt[0];
        end else if (hdlc_cfg1.frames == TSH_FR_ODD) begin
            rx_hits[0] = rx_hits[0] && rx_reg.frame_cnt[0];
        end
        rx_hits[1] = hdlc_hit(hdlc_cfg2, rx_slot, rx_bitpos, rx_reg.frame_cnt[0]);
        rx_hits[2] = hdlc_hit(hdlc_cfg3, rx_slot, rx_bitpos, rx_reg.frame_cnt[0]);
        if (marker_mode || rx_bitcnt == '0) begin
            rx_hits = '0;
        end
    end

    always_comb begin
        rx_next        = rx_reg;
        rx_next.sync_d = rx_sync_ff[1];
        if (rx_pulse && !marker_mode) begin
            rx_next.clk_cnt   = rx_ofs_mod;
            rx_next.frame_cnt = '0;
        end else if (rx_reg.clk_cnt >= frame_len - 1) begin
            rx_next.clk_cnt   = '0;
            rx_next.frame_cnt = (rx_reg.frame_cnt == 4'(TSH_MF_FRAMES - 1)) ? 4'h0
                              : rx_reg.frame_cnt + 4'h1;
        end else begin
            rx_next.clk_cnt = rx_reg.clk_cnt + 1'b1;
        end
        rx_next.marker = marker_mode && (rx_mk_dist < TSH_CW'(ratio));
        if (rx_base_edge) begin
            rx_next.pcm = rx_line_bit;
            rx_next.sig = rx_line_sig;
        end
        rx_next.hdlc_rx_bit   = rx_line_bit;
        rx_next.hdlc_rx_valid = rx_base_edge && (|rx_hits);
    end

    always_ff @(posedge rx_system_clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_reg <= '0;
        end else begin
            rx_reg <= rx_next;
        end
    end

    logic rx_out_neg, rx_mk_neg;
    always_ff @(negedge rx_system_clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_out_neg <= 1'b0;
            rx_mk_neg  <= 1'b0;
        end else begin
            rx_out_neg <= rx_reg.pcm;
            rx_mk_neg  <= rx_reg.marker;
        end
    end

    assign rx_pcm_output       = sys_edge_select[0] ? rx_out_neg : rx_reg.pcm;
    assign rx_frame_marker     = sys_edge_select[0] ? rx_mk_neg : rx_reg.marker;
    assign rx_signaling_output = rx_reg.sig;
    assign hdlc_rx_bit         = rx_reg.hdlc_rx_bit;
    assign hdlc_rx_valid       = rx_reg.hdlc_rx_valid;
    assign hdlc_rx_channels    = rx_hits;

    // ==========================================================
    // Transmit domain
    // ==========================================================
    logic [1:0] tx_sync_ff, tx_mf_ff;
    always_ff @(posedge tx_system_clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_sync_ff <= 2'h3;
            tx_mf_ff   <= 2'h3;
        end else begin
            tx_sync_ff <= {tx_sync_ff[0], tx_sync_pulse_n};
            tx_mf_ff   <= {tx_mf_ff[0], tx_multiframe_sync_n};
        end
    end

    tsh_tx_state_type tx_reg, tx_next;
    logic             tx_sync_now, tx_pulse;
    logic [TSH_CW-1:0] tx_bitcnt;
    logic [4:0]       tx_slot;
    logic             tx_base_edge, tx_equipped, tx_sig_sel, tx_in;

    assign tx_sync_now  = !(tx_sync_ff[1] && tx_mf_ff[1]);
    assign tx_pulse     = tx_sync_now && !tx_reg.sync_d;
    assign tx_bitcnt    = tx_reg.clk_cnt >> rshift;
    assign tx_slot      = (tx_bitcnt == '0) ? 5'h0 : 5'((tx_bitcnt - 1) >> 3);
    assign tx_base_edge = (tx_reg.clk_cnt & TSH_CW'(ratio - 4'h1)) == '0;
    assign tx_equipped  = tx_slot_select[5'd31 - tx_slot];

    logic [2:0] tx_bitpos;
    logic [2:0] tx_hits;
    assign tx_bitpos = 3'(tx_bitcnt - 1);
    always_comb begin
        tx_hits[0] = hdlc_slot_insert_enable && tx_equipped
                   && hdlc_cfg1.bit_mask[3'h7 - tx_bitpos]
                   && frame_ok(hdlc_cfg1.frames, tx_reg.frame_cnt[0]);
        tx_hits[1] = hdlc_hit(hdlc_cfg2, tx_slot, tx_bitpos, tx_reg.frame_cnt[0]);
        tx_hits[2] = hdlc_hit(hdlc_cfg3, tx_slot, tx_bitpos, tx_reg.frame_cnt[0]);
    end

    always_comb begin
        tx_sig_sel = tx_sig_mux_enable && tx_equipped
                   && (tx_reg.frame_cnt == 4'(TSH_MF_FRAMES - 1));
        tx_in = tx_sig_sel ? tx_signaling_input : tx_pcm_input;
    end

    always_comb begin
        tx_next        = tx_reg;
        tx_next.sync_d = tx_sync_now;
        if (tx_pulse) begin
            tx_next.clk_cnt   = tx_ofs_mod;
            tx_next.frame_cnt = '0;
        end else if (tx_reg.clk_cnt >= frame_len - 1) begin
            tx_next.clk_cnt   = '0;
            tx_next.frame_cnt = (tx_reg.frame_cnt == 4'(TSH_MF_FRAMES - 1)) ? 4'h0
                              : tx_reg.frame_cnt + 4'h1;
        end else begin
            tx_next.clk_cnt = tx_reg.clk_cnt + 1'b1;
        end
        tx_next.line_valid = tx_base_edge;
        tx_next.hdlc_take = tx_base_edge && (|tx_hits) && !tx_sig_mux_enable
                          && tx_bitcnt != '0;
        if (tx_base_edge) begin
            tx_next.line_bit = tx_next.hdlc_take ? hdlc_tx_bit : tx_in;
        end
    end

    always_ff @(posedge tx_system_clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= tx_next;
        end
    end

    assign tx_line_bit   = tx_reg.line_bit;
    assign tx_line_valid = tx_reg.line_valid;
    assign hdlc_tx_take  = tx_reg.hdlc_take;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_rx_reload;
        @(posedge rx_system_clock) disable iff (!rst_n)
        (rx_pulse && !marker_mode) |=> rx_reg.clk_cnt < frame_len
            && ({1'b0, rx_reg.clk_cnt} == {1'b0, $past(rx_offset)}
            || {1'b0, rx_reg.clk_cnt} + {1'b0, frame_len} == {1'b0, $past(rx_offset)});
    endproperty
    a_rx_reload: assert property (p_rx_reload) else $error("rx reload");

    property p_tx_reload;
        @(posedge tx_system_clock) disable iff (!rst_n)
        tx_pulse |=> tx_reg.clk_cnt < frame_len
            && ({1'b0, tx_reg.clk_cnt} == {1'b0, $past(tx_offset)}
            || {1'b0, tx_reg.clk_cnt} + {1'b0, frame_len} == {1'b0, $past(tx_offset)});
    endproperty
    a_tx_reload: assert property (p_tx_reload) else $error("tx reload");

    property p_marker_len;
        @(posedge rx_system_clock) disable iff (!rst_n)
        ($rose(rx_reg.marker) && ratio == 4'h1) |=> !rx_reg.marker;
    endproperty
    a_marker_len: assert property (p_marker_len) else $error("marker len");

    property p_marker_off;
        @(posedge rx_system_clock) disable iff (!rst_n)
        !marker_mode |=> !rx_reg.marker;
    endproperty
    a_marker_off: assert property (p_marker_off) else $error("marker off");

    property p_no_hdlc_marker;
        @(posedge rx_system_clock) disable iff (!rst_n)
        marker_mode |-> rx_hits == 3'h0;
    endproperty
    a_no_hdlc_marker: assert property (p_no_hdlc_marker) else $error("tsa on");

    property p_wrap;
        @(posedge rx_system_clock) disable iff (!rst_n)
        (rx_reg.clk_cnt == frame_len - 1 && !rx_pulse) |=> rx_reg.clk_cnt == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("rx wrap");

    property p_sig_frame;
        @(posedge tx_system_clock) disable iff (!rst_n)
        tx_sig_sel |-> tx_reg.frame_cnt == 4'(TSH_MF_FRAMES - 1);
    endproperty
    a_sig_frame: assert property (p_sig_frame) else $error("sig frame");

    property p_take_equipped;
        @(posedge tx_system_clock) disable iff (!rst_n)
        (tx_next.hdlc_take && !tx_hits[1] && !tx_hits[2])
            |-> tx_equipped && hdlc_slot_insert_enable;
    endproperty
    a_take_equipped: assert property (p_take_equipped) else $error("take idle");

    c_rx_sync: cover property (@(posedge rx_system_clock) rx_pulse);
    c_tx_sync: cover property (@(posedge tx_system_clock) tx_pulse);
    c_marker:  cover property (@(posedge rx_system_clock) rx_reg.marker);
    c_take:    cover property (@(posedge tx_system_clock) tx_reg.hdlc_take);
endmodule
`default_nettype wire

/* File: tsh_pkg.sv */
// Purpose: Constants and types for the T1 system highway offset and slot assigner block.
// Assumes: Registers are loaded over a plain parallel write port at the documented names.
// Notes:   Only the 1.544 MHz highway family is supported.
// Contract
// - Receive sync pulse and frame marker last exactly one basic bit period.
// - For T of 0 to 4, receive offset is 4-T+7*ratio.
// - For T from 5, receive offset is 200*ratio+4-T.
// - Receive clock is 1, 2, 4 or 8 times base rate; formulas scale.
// - Marker position counts receive clocks from F-bit, up to 193*ratio-1.
// - For marker positions to 193*ratio-3, offset is MP+2+7*ratio.
// - For the last two marker positions, offset is MP+2-186*ratio.
// - Transmit takes data and signaling inputs, same slots, idle slots ignored.
// - Transmit latching uses selected clock, sync pulse and transmit offset.
// - Signaling multiplex enable combines data and signaling by per-slot marker.
// - Marker high samples signaling input, marker low samples data input.
// - Signaling input used only in the last frame of each multiframe.
// - For transmit T of 0 to 4, offset is 3-T+7*ratio.
// - For transmit T from 5, offset is 200*ratio-T+3.
// - HDLC channel 1 uses any slot set, routed to buffers when enabled.
// - HDLC channels 2 and 3 use one common slot out of 24; code: each has its own slot field (hdlc_cfg2, hdlc_cfg3).
// - Each HDLC channel masks bits and chooses even, odd or both frames.
// - Slot 0 is bit 7 of the first select register, slot 31 bit 0.
// - Frame marker mode disables the slot assigner and offset programming; code: rx slot assigner only, rx_offset still places the marker.
// - Frame marker is high one base-rate cycle on the selected edge.
// - System data and markers use the edge selected per direction; code: sys_edge_select[0] sets rx PCM and marker only.
`default_nettype none
package tsh_pkg;
    localparam int          TSH_SLOTS      = 32;
    localparam int          TSH_FRAME_BITS = 193;
    localparam int          TSH_RX_PRE     = 7;
    localparam int          TSH_RX_TOTAL   = 200;
    localparam int          TSH_RX_SHORT_T = 4;
    localparam int          TSH_RX_K       = 4;
    localparam int          TSH_TX_K       = 3;
    localparam int          TSH_MK_K       = 2;
    localparam int          TSH_MK_WRAP    = 186;
    localparam int          TSH_MK_TAIL    = 3;
    localparam int          TSH_MF_FRAMES  = 12;
    localparam int          TSH_CW         = 11;
    localparam logic [2:0]  TSH_RX_MARKER  = 3'h1;
    localparam logic [7:0]  TSH_SEL_RESET  = 8'h00;
    localparam logic [10:0] TSH_OFS_RESET  = 11'h000;
    localparam logic [1:0]  TSH_FR_BOTH    = 2'h0;
    localparam logic [1:0]  TSH_FR_EVEN    = 2'h1;
    localparam logic [1:0]  TSH_FR_ODD     = 2'h2;

    typedef struct packed {
        logic [TSH_CW-1:0] clk_cnt;
        logic [3:0]        frame_cnt;
        logic              sync_d;
        logic              pcm;
        logic              sig;
        logic              marker;
        logic              hdlc_rx_bit;
        logic              hdlc_rx_valid;
    } tsh_rx_state_type;

    typedef struct packed {
        logic [TSH_CW-1:0] clk_cnt;
        logic [3:0]        frame_cnt;
        logic              sync_d;
        logic              line_bit;
        logic              line_valid;
        logic              hdlc_take;
    } tsh_tx_state_type;

    typedef struct packed {
        logic [1:0] frames;
        logic [7:0] bit_mask;
        logic [4:0] slot;
    } tsh_hdlc_cfg_type;
endpackage
`default_nettype wire

/* File: tsh_hwy_partner.sv */
// Purpose: Behavioural highway partner that sends sync pulses and transmit levels.
// Assumes: One sync pulse per frame, placed within the allowed sync distance.
// Notes:   Each pulse lasts one base bit, that is ratio system clocks.
`default_nettype none
module tsh_hwy_partner (
    input  wire logic       rx_system_clock,
    input  wire logic       tx_system_clock,
    input  wire logic [3:0] ratio,
    input  wire logic       pcm_level,
    input  wire logic       sig_level,
    output logic            rx_sync_pulse_n,
    output logic            tx_sync_pulse_n,
    output logic            tx_multiframe_sync_n,
    output logic            tx_pcm_input,
    output logic            tx_signaling_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // Pin drivers.
    initial begin
        rx_sync_pulse_n = 1'b1;
        tx_sync_pulse_n = 1'b1;
        tx_multiframe_sync_n = 1'b1;
        tx_pcm_input = 1'b0;
        tx_signaling_input = 1'b0;
    end
    always @(negedge tx_system_clock) begin
        tx_pcm_input <= pcm_level;
        tx_signaling_input <= sig_level;
    end
    // one bit pulse
    // Which pulse: 0 receive sync, 1 transmit sync, 2 transmit multiframe sync.
    task automatic send_sync(input logic [1:0] which);
        if (which != 2'h0) begin
            @(negedge tx_system_clock);
            if (which == 2'h1) tx_sync_pulse_n <= 1'b0;
            else tx_multiframe_sync_n <= 1'b0;
            repeat (ratio) @(negedge tx_system_clock);
            tx_sync_pulse_n <= 1'b1;
            tx_multiframe_sync_n <= 1'b1;
        end else begin
            @(negedge rx_system_clock);
            rx_sync_pulse_n <= 1'b0;
            repeat (ratio) @(negedge rx_system_clock);
            rx_sync_pulse_n <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

/* File: tsh_highway_tb.sv */
// Purpose: Self-checking bench for the highway offsets and the slot assigner.
// Assumes: Offsets are worked out here from the sync distance or marker position.
// Notes:   Frame positions are compared modulo the frame length.
`default_nettype none
module tsh_highway_tb
    import tsh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              rxc, txc, rst_n, tx_sig_mux_enable, hdlc_slot_insert_enable;
    logic              rx_line_bit, rx_line_sig, hdlc_tx_bit, pcm_lv, sig_lv;
    logic [1:0]        sys_clock_rate_select, sys_edge_select;
    logic [2:0]        rx_pin_function;
    logic [TSH_CW-1:0] rx_offset, tx_offset;
    logic [31:0]       rx_slot_select, tx_slot_select;
    tsh_hdlc_cfg_type  hdlc_cfg1, hdlc_cfg2, hdlc_cfg3;
    logic              rx_sync_pulse_n, tx_sync_pulse_n, tx_multiframe_sync_n;
    logic              tx_pcm_input, tx_signaling_input, rx_frame_marker, hdlc_rx_valid;
    logic              tx_line_bit, tx_line_valid, hdlc_tx_take;
    logic              rx_pcm_output, rx_signaling_output, hdlc_rx_bit;
    int                fail_count, checked, cyc;
    // =====================================================================
    // Clocks and instances.
    initial begin
        rxc = 1'b0;
        forever #5 rxc = ~rxc;
    end
    initial begin
        txc = 1'b0;
        #7;
        forever #15 txc = ~txc;
    end
    always @(posedge rxc) cyc <= cyc + 1;
    tsh_highway #(.RATIO_MAX(8)) u_dut (
        .rst_n, .rx_system_clock(rxc), .tx_system_clock(txc), .sys_clock_rate_select,
        .sys_edge_select, .rx_pin_function, .rx_offset, .tx_offset, .rx_slot_select,
        .tx_slot_select, .tx_sig_mux_enable, .hdlc_slot_insert_enable, .hdlc_cfg1,
        .hdlc_cfg2, .hdlc_cfg3, .rx_sync_pulse_n, .tx_sync_pulse_n, .tx_multiframe_sync_n,
        .rx_line_bit, .rx_line_sig, .tx_pcm_input, .tx_signaling_input, .hdlc_tx_bit,
        .rx_pcm_output, .rx_signaling_output, .rx_frame_marker, .hdlc_rx_bit,
        .hdlc_rx_valid, .hdlc_rx_channels(), .tx_line_bit, .tx_line_valid, .hdlc_tx_take
    );
    tsh_hwy_partner u_hwy (
        .rx_system_clock(rxc), .tx_system_clock(txc), .ratio(4'(1 << sys_clock_rate_select)),
        .pcm_level(pcm_lv), .sig_level(sig_lv), .rx_sync_pulse_n, .tx_sync_pulse_n,
        .tx_multiframe_sync_n, .tx_pcm_input, .tx_signaling_input
    );
    // =====================================================================
    // Shared tasks.
    task automatic test_done();
        $display("fail_count=%0d checked=%0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
        end
    endtask
    task automatic timeout();
        fail_count++;
        $display("ERROR at %0t: wait ran out", $time);
        test_done();
    endtask
    task automatic do_reset(input logic [1:0] sel);
        rst_n = 1'b0;
        sys_clock_rate_select = sel;
        repeat (8) @(negedge rxc);
        rst_n = 1'b1;
        repeat (4) @(negedge txc);
    endtask
    // Counts sampled highs over n cycles after letting the settings settle.
    task automatic count(input int which, input int n, output int c);
        c = 0;
        for (int i = -8; i < n; i++) begin
            if (which == 0) @(negedge rxc);
            else @(negedge txc);
            if (i >= 0 && which == 0) c += int'(hdlc_rx_valid === 1'b1);
            if (i >= 0 && which == 1) c += int'(hdlc_tx_take === 1'b1);
            if (i >= 0 && which == 2) c += int'(tx_line_valid === 1'b1 && tx_line_bit === 1'b1);
        end
    endtask
    task automatic find_mark(output int at, output int w);
        logic prev;
        prev = 1'b1;
        at = -1;
        w = 0;
        for (int i = 0; i < 4000 && at < 0; i++) begin
            @(negedge rxc);
            if (rx_frame_marker === 1'b1 && prev !== 1'b1) at = cyc;
            prev = rx_frame_marker;
        end
        if (at < 0) timeout();
        while (rx_frame_marker === 1'b1 && w < 20) begin
            w++;
            @(negedge rxc);
        end
    endtask
    // =====================================================================
    // Scenarios.
    task automatic t_rx_path();
        for (int e = 0; e < 2; e++) begin
            sys_edge_select = 2'(e);
            {rx_line_bit, rx_line_sig} = 2'h2;
            repeat (4) @(negedge rxc);
            check({rx_pcm_output, rx_signaling_output, hdlc_rx_bit}, 3'h5, "rx high");
            {rx_line_bit, rx_line_sig} = 2'h1;
            repeat (4) @(negedge rxc);
            check({rx_pcm_output, rx_signaling_output, hdlc_rx_bit}, 3'h2, "rx low");
        end
        sys_edge_select = 2'h0;
        {rx_line_bit, rx_line_sig} = 2'h0;
    endtask
    task automatic t_hdlc_rx();
        int c;
        hdlc_slot_insert_enable = 1'b1;
        rx_slot_select = 32'h8000_0100;
        count(0, 193, c);
        check(c, 16, "ch1 slots 0 and 23");
        hdlc_cfg1.bit_mask = 8'h0f;
        count(0, 193, c);
        check(c, 8, "ch1 masked bits");
        hdlc_cfg1 = '{TSH_FR_EVEN, 8'hff, 5'h00};
        count(0, 386, c);
        check(c, 16, "ch1 even frames");
        hdlc_cfg1.frames = TSH_FR_ODD;
        count(0, 386, c);
        check(c, 16, "ch1 odd frames");
        hdlc_slot_insert_enable = 1'b0;
        count(0, 193, c);
        check(c, 0, "ch1 insertion off");
        hdlc_cfg2.bit_mask = 8'hff;
        count(0, 193, c);
        check(c, 8, "ch2 rx slot");
        count(1, 193, c);
        check(c, 8, "ch2 tx slot");
        hdlc_tx_bit = 1'b1;
        count(2, 193, c);
        check(c, 8, "ch2 tx bits inserted");
        hdlc_tx_bit = 1'b0;
        hdlc_cfg2.bit_mask = 8'h00;
        hdlc_cfg3.bit_mask = 8'h81;
        count(0, 193, c);
        check(c, 2, "ch3 masked slot");
        hdlc_cfg3.bit_mask = 8'h00;
    endtask
    task automatic t_tx_mux();
        int c;
        sig_lv = 1'b1;
        tx_sig_mux_enable = 1'b1;
        tx_slot_select = 32'h0400_0000;
        count(2, TSH_MF_FRAMES * TSH_FRAME_BITS, c);
        check(c, 8, "signaling in last frame only");
        tx_slot_select = 32'h0;
        count(2, TSH_MF_FRAMES * TSH_FRAME_BITS, c);
        check(c, 0, "unmarked slot takes data");
        tx_slot_select = 32'h0400_0000;
        tx_sig_mux_enable = 1'b0;
        count(2, TSH_MF_FRAMES * TSH_FRAME_BITS, c);
        check(c, 0, "mux off ignores signaling");
        tx_sig_mux_enable = 1'b1;
        {pcm_lv, sig_lv} = 2'h2;
        count(2, TSH_MF_FRAMES * TSH_FRAME_BITS, c);
        check(c, TSH_MF_FRAMES * TSH_FRAME_BITS - 8, "data outside marked slot");
        {pcm_lv, sig_lv, tx_sig_mux_enable} = '0;
    endtask
    task automatic t_offset(input logic tx);
        int ts[5] = '{0, 4, 5, 20, 192};
        int base, n, x;
        logic cur, prev;
        hdlc_slot_insert_enable = 1'b1;
        rx_slot_select = 32'h8000_0000;
        tx_slot_select = 32'h8000_0000;
        hdlc_cfg1 = '{TSH_FR_BOTH, 8'hff, 5'h00};
        base = 0;
        for (int k = 0; k < 5; k++) begin
            x = (ts[k] <= 4 ? 7 : 200) + (tx ? 3 : 4) - ts[k];
            if (tx) tx_offset = 11'(x);
            else rx_offset = 11'(x);
            u_hwy.send_sync(tx ? 2'(1 + k % 2) : 2'h0);
            prev = 1'b1;
            for (n = 0; n < 400; n++) begin
                if (tx) @(negedge txc);
                else @(negedge rxc);
                cur = tx ? hdlc_tx_take : hdlc_rx_valid;
                if (n > 3 && cur === 1'b1 && prev !== 1'b1) break;
                prev = cur;
            end
            if (n == 400) timeout();
            if (k == 0) base = n;
            else check((n - base + 386) % 193, ts[k], "frame start shift");
        end
    endtask
    task automatic t_marker();
        int mp[4] = '{0, 100, 188, 192};
        int at, w, base, nxt;
        rx_pin_function = TSH_RX_MARKER;
        base = 0;
        for (int k = 0; k < 4; k++) begin
            rx_offset = 11'(mp[k] + 2 + (mp[k] <= 190 ? 7 : -186));
            repeat (200) @(negedge rxc);
            find_mark(at, w);
            check(w, 1, "marker width");
            if (k == 0) base = at;
            else check((at - base) % 193, mp[k], "marker position");
        end
        u_hwy.send_sync(2'h0);
        find_mark(nxt, w);
        check((nxt - base) % 193, 192, "marker ignores sync");
        for (int s = 1; s < 4; s += 2) begin
            do_reset(2'(s));
            rx_offset = 11'(2 + 7 * (1 << s));
            find_mark(at, w);
            find_mark(nxt, w);
            check(w, 1 << s, "scaled marker width");
            check(nxt - at, 193 << s, "scaled frame length");
        end
    endtask
    initial begin
        fail_count = 0;
        checked = 0;
        cyc = 0;
        {sys_edge_select, rx_pin_function, rx_offset, tx_offset} = '0;
        {rx_slot_select, tx_slot_select, tx_sig_mux_enable, hdlc_slot_insert_enable} = '0;
        {rx_line_bit, rx_line_sig, hdlc_tx_bit, pcm_lv, sig_lv} = '0;
        hdlc_cfg1 = '{TSH_FR_BOTH, 8'hff, 5'h00};
        hdlc_cfg2 = '{TSH_FR_BOTH, 8'h00, 5'h03};
        hdlc_cfg3 = hdlc_cfg2;
        do_reset(2'h0);
        t_rx_path();
        t_hdlc_rx();
        t_tx_mux();
        t_offset(1'b0);
        t_offset(1'b1);
        t_marker();
        test_done();
    end
endmodule
`default_nettype wire
